// ===== core/cfss_defs.svh
/*
  Bit positions, reset values and fixed figures for the flags,
  segment and control register state of the core.
  Assumes it is included by bare name from core/ sources.
*/
`ifndef CFSS_DEFS_SVH
`define CFSS_DEFS_SVH

// Flags register fields
`define CFSS_CF_BIT        0
`define CFSS_PF_BIT        2
`define CFSS_AF_BIT        4
`define CFSS_ZF_BIT        6
`define CFSS_SF_BIT        7
`define CFSS_TF_BIT        8
`define CFSS_IF_BIT        9
`define CFSS_DF_BIT        10
`define CFSS_OF_BIT        11
`define CFSS_IO_PRIVILEGE_LEVEL_LO       12
`define CFSS_IO_PRIVILEGE_LEVEL_HI       13
`define CFSS_FLAGS_POP_MASK 32'h0000_0DD5
`define CFSS_FLAGS_RST     32'h0000_0000

// Machine control register fields
`define CFSS_PE_BIT        0
`define CFSS_RSV_BIT       4
`define CFSS_PG_BIT        31
`define CFSS_CR0_RSV_MASK  32'h0000_0010
`define CFSS_CR0_RST       32'h0000_0000
`define CFSS_CR3_IGN_MASK  32'hFFFF_F000
`define CFSS_CR0_NUM       2'h0
`define CFSS_CR2_NUM       2'h2
`define CFSS_CR3_NUM       2'h3

// Segment descriptor cache
`define CFSS_NSEG          6
`define CFSS_REAL_LIMIT    32'h0000_FFFF
`define CFSS_REAL_ATTR     8'h93
`define CFSS_ATTR_PRESENT  7
`define CFSS_ATTR_CODE     3
`define CFSS_ATTR_RW       1

// Exception vectors
`define CFSS_VEC_DEBUG     8'h01
`define CFSS_VEC_GPF       8'h0D

`endif

// ===== core/cfss_pkg.sv
/*
  Types shared by the flags, segment and control state logic.
  Assumes nothing of its surroundings.
*/
package cfss_pkg;

  typedef enum logic [1:0] {
    SZ8  = 2'h0,
    SZ16 = 2'h1,
    SZ32 = 2'h2
  } cfss_size_t;

  typedef enum logic [2:0] {
    SEG_CODE  = 3'h0,
    SEG_STACK = 3'h1,
    SEG_DATA1 = 3'h2,
    SEG_DATA2 = 3'h3,
    SEG_DATA3 = 3'h4,
    SEG_DATA4 = 3'h5
  } cfss_seg_t;

  typedef enum logic [1:0] {
    ACC_READ  = 2'h0,
    ACC_WRITE = 2'h1,
    ACC_EXEC  = 2'h2
  } cfss_acc_t;

endpackage

// ===== core/cfss_flag_gen.sv
/*
  Combinational arithmetic status flag generator for add and
  subtract at 8, 16 or 32 bit operand size.
  Assumes the caller registers the outputs.
*/
`timescale 1ns/1ps
`default_nettype none

module cfss_flag_gen (
  // Operands
  input  wire logic [31:0] a_i,
  input  wire logic [31:0] b_i,
  input  wire logic        sub_i,
  input  wire logic [1:0]  size_i,
  // Result and flags
  output logic      [31:0] res_o,
  output logic             cf_o,
  output logic             of_o,
  output logic             sf_o,
  output logic             zf_o,
  output logic             af_o,
  output logic             pf_o
);

  logic [31:0] mask;
  logic [4:0]  msb_idx;
  logic [5:0]  cout_idx;
  logic [31:0] am;
  logic [31:0] bm;
  logic [32:0] sum;
  logic        c_out;
  logic        c_in;

  always_comb
  begin
    case (size_i)
      cfss_pkg::SZ8:
      begin
        mask    = 32'h0000_00FF;
        msb_idx = 5'h07;
      end
      cfss_pkg::SZ16:
      begin
        mask    = 32'h0000_FFFF;
        msb_idx = 5'h0F;
      end
      default:
      begin
        mask    = 32'hFFFF_FFFF;
        msb_idx = 5'h1F;
      end
    endcase
  end

  assign cout_idx = {1'b0, msb_idx} + 6'h01;
  assign am       = a_i & mask;
  assign bm       = (sub_i ? ~b_i : b_i) & mask;
  assign sum      = {1'b0, am} + {1'b0, bm} + {32'h0000_0000, sub_i};
  assign res_o    = sum[31:0] & mask;
  // Carry out of, and into, the sign position
  assign c_out    = sum[cout_idx];
  assign c_in     = sum[msb_idx] ^ am[msb_idx] ^ bm[msb_idx];
  assign of_o     = c_in ^ c_out;                  // see RL1
  assign cf_o     = c_out ^ sub_i;                 // see RL11
  assign sf_o     = sum[msb_idx];                  // see RL7
  assign zf_o     = (res_o == 32'h0000_0000);      // see RL8
  assign af_o     = a_i[4] ^ b_i[4] ^ sum[4];      // see RL9
  assign pf_o     = ~^sum[7:0];                    // see RL10

endmodule

`default_nettype wire

// ===== core/cfss_state.sv
/*
  Flags register, six segment selectors with descriptor caches,
  memory reference translation and check, control registers 0/2/3,
  string index stepping, interrupt gating and debug trap request.
  Assumes the instruction sequencer on sys_clk_i drives all request
  inputs; only the maskable interrupt pin is asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cfss_defs.svh"

// Functional notes
// RL1: Overflow when sign-bit carry in and out differ
// RL2: String indexes step up or down by direction
// RL3: Maskable interrupt passes only with enable flag
// RL4: Popped enable flag changes only if privileged enough
// RL5: Single-step flag traps after next instruction
// RL6: Without single-step, trap only on breakpoint match
// RL7: Sign flag is result top bit
// RL8: Zero flag when whole result is zero
// RL9: Aux carry from bit 3 carry or borrow
// RL10: Parity flag even ones in low byte
// RL11: Carry flag from top bit carry or borrow
// RL12: Six sixteen-bit segment selector registers
// RL13: Protected limits to 4 Gbytes, real fixed 64K
// RL14: Limit violation, including wrap, raises exception 13
// RL15: Each selector has base, limit, attribute cache
// RL16: Real-mode load sets only base, selector times sixteen
// RL17: Protected load fills cache from indexed descriptor
// RL18: References add base, check limit and attributes
// RL19: Status word access touches low sixteen bits only
// RL20: Paging enabled while control bit 31 set
// RL21: Software keeps reserved control bit 4 unchanged
// RL22: Three control registers 0, 2, 3 readable writable
// RL23: I/O privilege level held in flags bits 12-13
// RL24: Cache update precedes later references to segment
module cfss_state (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        ce_i,
  // Arithmetic result flags
  input  wire logic        alu_valid_i,
  input  wire logic        alu_sub_i,
  input  wire logic [1:0]  alu_size_i,
  input  wire logic [31:0] alu_a_i,
  input  wire logic [31:0] alu_b_i,
  // Flags image pop
  input  wire logic        flags_wr_i,
  input  wire logic [31:0] flags_wdata_i,
  input  wire logic [1:0]  cpl_i,
  output logic      [31:0] flags_o,
  // String index stepping
  input  wire logic        str_step_i,
  input  wire logic [1:0]  str_size_i,
  input  wire logic [31:0] str_src_i,
  input  wire logic [31:0] str_dst_i,
  output logic      [31:0] str_src_o,
  output logic      [31:0] str_dst_o,
  // Interrupt and debug
  input  wire logic        maskable_interrupt_input_i,
  output logic             int_req_o,
  input  wire logic        instr_done_i,
  input  wire logic [3:0]  bp_match_i,
  output logic             debug_trap_o,
  output logic [7:0]       fault_vec_o,
  // Segment selector load
  input  wire logic        seg_load_i,
  input  wire logic [2:0]  seg_idx_i,
  input  wire logic [15:0] seg_sel_i,
  input  wire logic [31:0] desc_base_i,
  input  wire logic [31:0] desc_limit_i,
  input  wire logic [7:0]  desc_attr_i,
  input  wire logic [2:0]  seg_rd_idx_i,
  output logic      [15:0] seg_sel_o,
  // Memory reference
  input  wire logic        mem_req_i,
  input  wire logic [2:0]  mem_seg_i,
  input  wire logic [31:0] mem_off_i,
  input  wire logic [1:0]  mem_len_i,
  input  wire logic [1:0]  mem_acc_i,
  output logic             mem_valid_o,
  output logic      [31:0] mem_lin_o,
  output logic             mem_fault_o,
  // Control registers
  input  wire logic        cr_wr_i,
  input  wire logic        cr_rd_i,
  input  wire logic [1:0]  cr_num_i,
  input  wire logic [31:0] cr_wdata_i,
  input  wire logic        msw_load_i,
  input  wire logic        msw_store_i,
  output logic      [31:0] cr_rdata_o,
  output logic             paging_enable_o,
  output logic             protect_mode_o
);

  logic [31:0] flags_reg;
  logic [31:0] flags_pop_next;
  logic [31:0] flags_alu_next;
  logic [1:0]  io_privilege_level;
  logic [31:0] alu_res;
  logic        gen_cf;
  logic        gen_of;
  logic        gen_sf;
  logic        gen_zf;
  logic        gen_af;
  logic        gen_pf;
  logic [31:0] str_delta;
  logic [31:0] str_src_reg;
  logic [31:0] str_dst_reg;
  logic        irq_meta_reg;
  logic        irq_sync_reg;
  logic        debug_trap_reg;
  logic [7:0]  fault_vec_reg;
  logic [15:0] sel_reg   [`CFSS_NSEG];
  logic [31:0] base_reg  [`CFSS_NSEG];
  logic [31:0] limit_reg [`CFSS_NSEG];
  logic [7:0]  attr_reg  [`CFSS_NSEG];
  logic [15:0] seg_sel_reg;
  logic        pe;
  logic [31:0] ld_base;
  logic [2:0]  ref_idx;
  logic        seg_ok;
  logic        fwd;
  logic [31:0] ref_base;
  logic [31:0] ref_limit;
  logic [7:0]  ref_attr;
  logic [32:0] ref_end;
  logic        attr_bad;
  logic        ref_fault;
  logic        mem_valid_reg;
  logic        mem_fault_reg;
  logic [31:0] mem_lin_reg;
  logic [31:0] cr0_reg;
  logic [31:0] cr2_reg;
  logic [31:0] cr3_reg;
  logic [31:0] cr0_wr_next;
  logic [31:0] load_status_word_instr_next;
  logic [31:0] cr_rdata_reg;

  assign io_privilege_level =
    flags_reg[`CFSS_IO_PRIVILEGE_LEVEL_HI:`CFSS_IO_PRIVILEGE_LEVEL_LO];       // see RL23
  assign pe = cr0_reg[`CFSS_PE_BIT];

  cfss_flag_gen u_flag_gen (
    .a_i    (alu_a_i),
    .b_i    (alu_b_i),
    .sub_i  (alu_sub_i),
    .size_i (alu_size_i),
    .res_o  (alu_res),
    .cf_o   (gen_cf),
    .of_o   (gen_of),
    .sf_o   (gen_sf),
    .zf_o   (gen_zf),
    .af_o   (gen_af),
    .pf_o   (gen_pf)
  );

  // Flags register: pop wins over arithmetic update
  always_comb
  begin
    flags_pop_next = (flags_reg & ~`CFSS_FLAGS_POP_MASK) |
                     (flags_wdata_i & `CFSS_FLAGS_POP_MASK);
    if (cpl_i <= io_privilege_level)                // see RL4
      flags_pop_next[`CFSS_IF_BIT] = flags_wdata_i[`CFSS_IF_BIT];
    if (cpl_i == 2'h0)
      flags_pop_next[`CFSS_IO_PRIVILEGE_LEVEL_HI:`CFSS_IO_PRIVILEGE_LEVEL_LO] =
        flags_wdata_i[`CFSS_IO_PRIVILEGE_LEVEL_HI:`CFSS_IO_PRIVILEGE_LEVEL_LO];
  end

  always_comb
  begin
    flags_alu_next               = flags_reg;
    flags_alu_next[`CFSS_OF_BIT] = gen_of;          // see RL1
    flags_alu_next[`CFSS_SF_BIT] = gen_sf;          // see RL7
    flags_alu_next[`CFSS_ZF_BIT] = gen_zf;          // see RL8
    flags_alu_next[`CFSS_AF_BIT] = gen_af;          // see RL9
    flags_alu_next[`CFSS_PF_BIT] = gen_pf;          // see RL10
    flags_alu_next[`CFSS_CF_BIT] = gen_cf;          // see RL11
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      flags_reg <= `CFSS_FLAGS_RST;
    else if (ce_i)
    begin
      if (flags_wr_i)
        flags_reg <= flags_pop_next;
      else if (alu_valid_i)
        flags_reg <= flags_alu_next;
    end
  end

  // String index stepping
  always_comb
  begin
    case (str_size_i)
      cfss_pkg::SZ8:  str_delta = 32'h0000_0001;
      cfss_pkg::SZ16: str_delta = 32'h0000_0002;
      default:        str_delta = 32'h0000_0004;
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      str_src_reg <= 32'h0000_0000;
      str_dst_reg <= 32'h0000_0000;
    end
    else if (ce_i && str_step_i)
    begin
      if (flags_reg[`CFSS_DF_BIT])                  // see RL2
      begin
        str_src_reg <= str_src_i - str_delta;
        str_dst_reg <= str_dst_i - str_delta;
      end
      else
      begin
        str_src_reg <= str_src_i + str_delta;
        str_dst_reg <= str_dst_i + str_delta;
      end
    end
  end

  // Interrupt pin synchroniser
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      irq_meta_reg <= 1'b0;
      irq_sync_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      irq_meta_reg <= maskable_interrupt_input_i;
      irq_sync_reg <= irq_meta_reg;
    end
  end

  assign int_req_o = irq_sync_reg & flags_reg[`CFSS_IF_BIT]; // see RL3

  // Debug trap and fault vector
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      debug_trap_reg <= 1'b0;
    else if (ce_i)
      debug_trap_reg <= instr_done_i &&
        (flags_reg[`CFSS_TF_BIT] || (|bp_match_i)); // see RL5 RL6
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      fault_vec_reg <= 8'h00;
    else if (ce_i)
    begin
      if (mem_req_i && ref_fault)
        fault_vec_reg <= `CFSS_VEC_GPF;             // see RL14
      else if (instr_done_i &&
               (flags_reg[`CFSS_TF_BIT] || (|bp_match_i)))
        fault_vec_reg <= `CFSS_VEC_DEBUG;
    end
  end

  // Segment selectors and descriptor caches
  assign ld_base = pe ? desc_base_i : {12'h000, seg_sel_i, 4'h0};

  genvar g;
  generate
    for (g = 0; g < `CFSS_NSEG; g = g + 1)
    begin : g_seg
      always_ff @(posedge sys_clk_i or posedge sys_rst_i)
      begin
        if (sys_rst_i)
        begin
          sel_reg[g]   <= 16'h0000;
          base_reg[g]  <= 32'h0000_0000;
          limit_reg[g] <= `CFSS_REAL_LIMIT;
          attr_reg[g]  <= `CFSS_REAL_ATTR;
        end
        else if (ce_i && seg_load_i && seg_idx_i == 3'(g))
        begin
          sel_reg[g]  <= seg_sel_i;                 // see RL12
          base_reg[g] <= ld_base;                   // see RL15 RL16
          if (pe)
          begin
            limit_reg[g] <= desc_limit_i;           // see RL17
            attr_reg[g]  <= desc_attr_i;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      seg_sel_reg <= 16'h0000;
    else if (ce_i)
      seg_sel_reg <= (seg_rd_idx_i < 3'(`CFSS_NSEG)) ?
                     sel_reg[seg_rd_idx_i] : 16'h0000;
  end

  // Memory reference: forward a same-cycle load
  assign seg_ok  = mem_seg_i < 3'(`CFSS_NSEG);
  assign ref_idx = seg_ok ? mem_seg_i : 3'h0;
  assign fwd     = seg_load_i && (seg_idx_i == mem_seg_i); // see RL24
  assign ref_base  = fwd ? ld_base : base_reg[ref_idx];
  assign ref_limit = !pe ? `CFSS_REAL_LIMIT :       // see RL13
                     fwd ? desc_limit_i : limit_reg[ref_idx];
  assign ref_attr  = fwd ? desc_attr_i : attr_reg[ref_idx];
  assign ref_end   = {1'b0, mem_off_i} + {31'h0000_0000, mem_len_i};

  always_comb
  begin
    attr_bad = 1'b0;
    if (pe)
    begin
      if (!ref_attr[`CFSS_ATTR_PRESENT])
        attr_bad = 1'b1;
      else
      begin
        case (mem_acc_i)
          cfss_pkg::ACC_WRITE:
            attr_bad = ref_attr[`CFSS_ATTR_CODE] ||
                       !ref_attr[`CFSS_ATTR_RW];
          cfss_pkg::ACC_EXEC:
            attr_bad = !ref_attr[`CFSS_ATTR_CODE];
          default:
            attr_bad = ref_attr[`CFSS_ATTR_CODE] &&
                       !ref_attr[`CFSS_ATTR_RW];
        endcase
      end
    end
  end

  // Wrap past the top of the space counts as a limit violation
  assign ref_fault = !seg_ok || attr_bad || ref_end[32] ||
                     (ref_end[31:0] > ref_limit);   // see RL14 RL18

  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      mem_valid_reg <= 1'b0;
      mem_fault_reg <= 1'b0;
      mem_lin_reg   <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      mem_valid_reg <= mem_req_i;
      mem_fault_reg <= mem_req_i && ref_fault;
      if (mem_req_i)
        mem_lin_reg <= ref_base + mem_off_i;        // see RL18
    end
  end

  // Control registers; reserved bit 4 held by hardware too
  assign cr0_wr_next = (cr_wdata_i & ~`CFSS_CR0_RSV_MASK) |
                       (cr0_reg & `CFSS_CR0_RSV_MASK); // see RL21
  assign load_status_word_instr_next = {cr0_reg[31:16], cr_wdata_i[15:5],
                      cr0_reg[`CFSS_RSV_BIT], cr_wdata_i[3:1],
                      cr_wdata_i[0] | cr0_reg[`CFSS_PE_BIT]};

  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      cr0_reg <= `CFSS_CR0_RST;
      cr2_reg <= 32'h0000_0000;
      cr3_reg <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      if (msw_load_i)
        cr0_reg <= load_status_word_instr_next;                       // see RL19
      else if (cr_wr_i)
      begin
        case (cr_num_i)                             // see RL22
          `CFSS_CR0_NUM: cr0_reg <= cr0_wr_next;
          `CFSS_CR2_NUM: cr2_reg <= cr_wdata_i;
          `CFSS_CR3_NUM: cr3_reg <= cr_wdata_i & `CFSS_CR3_IGN_MASK;
          default:       cr0_reg <= cr0_reg;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      cr_rdata_reg <= 32'h0000_0000;
    else if (ce_i)
    begin
      if (msw_store_i)
        cr_rdata_reg <= {16'h0000, cr0_reg[15:0]};  // see RL19
      else if (cr_rd_i)
      begin
        case (cr_num_i)
          `CFSS_CR0_NUM: cr_rdata_reg <= cr0_reg;
          `CFSS_CR2_NUM: cr_rdata_reg <= cr2_reg;
          `CFSS_CR3_NUM: cr_rdata_reg <= cr3_reg;
          default:       cr_rdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign flags_o         = flags_reg;
  assign str_src_o       = str_src_reg;
  assign str_dst_o       = str_dst_reg;
  assign debug_trap_o    = debug_trap_reg;
  assign fault_vec_o     = fault_vec_reg;
  assign seg_sel_o       = seg_sel_reg;
  assign mem_valid_o     = mem_valid_reg;
  assign mem_fault_o     = mem_fault_reg;
  assign mem_lin_o       = mem_lin_reg;
  assign cr_rdata_o      = cr_rdata_reg;
  assign paging_enable_o = cr0_reg[`CFSS_PG_BIT];   // see RL20
  assign protect_mode_o  = pe;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_alu;
    ce_i && alu_valid_i && !flags_wr_i;
  endsequence
  sequence s_step_done;
    ce_i && instr_done_i && flags_o[`CFSS_TF_BIT];
  endsequence

  AST_OVERFLOW: assert property (s_alu ##0 alu_size_i == 2'h0 |=> // see RL1
    flags_o[`CFSS_OF_BIT] == ($past(alu_a_i[7]) ==
    ($past(alu_b_i[7]) ^ $past(alu_sub_i)) &&
    $past(alu_res[7]) != $past(alu_a_i[7])))
    else $error("overflow flag wrong");
  AST_STR_DIR: assert property (ce_i && str_step_i && // see RL2
    flags_o[`CFSS_DF_BIT] |=> str_src_o < $past(str_src_i) ||
    $past(str_src_i) < 32'h0000_0004)
    else $error("string index moved the wrong way");
  AST_INT_GATE: assert property ($rose(int_req_o) |-> // see RL3
    flags_o[`CFSS_IF_BIT])
    else $error("interrupt passed while disabled");
  AST_IF_PRIV: assert property (ce_i && flags_wr_i && // see RL4
    cpl_i > io_privilege_level |=> $stable(flags_o[`CFSS_IF_BIT]))
    else $error("enable flag changed without privilege");
  AST_STEP_TRAP: assert property (s_step_done |=> // see RL5
    debug_trap_o && fault_vec_o == `CFSS_VEC_DEBUG ||
    $past(mem_req_i))
    else $error("single step trap missing");
  AST_NO_TRAP: assert property (ce_i && instr_done_i && // see RL6
    !flags_o[`CFSS_TF_BIT] && bp_match_i == 4'h0 |=> !debug_trap_o)
    else $error("debug trap without cause");
  AST_ZERO: assert property (s_alu |=> flags_o[`CFSS_ZF_BIT] == // see RL8
    ($past(alu_res) == 32'h0000_0000))
    else $error("zero flag wrong");
  AST_PARITY: assert property (s_alu |=> // see RL10
    flags_o[`CFSS_PF_BIT] == ~^$past(alu_res[7:0]))
    else $error("parity flag wrong");
  AST_WRAP: assert property (ce_i && mem_req_i && // see RL14
    ref_end[32] |=> mem_fault_o ##0 fault_vec_o == `CFSS_VEC_GPF)
    else $error("wrap not faulted");
  AST_REAL_FWD: assert property (ce_i && seg_load_i && mem_req_i && // see RL24
    !pe && seg_idx_i == mem_seg_i |=> mem_lin_o ==
    {12'h000, $past(seg_sel_i), 4'h0} + $past(mem_off_i))
    else $error("reference missed same-cycle load");
  AST_MSW_UPPER: assert property (ce_i && msw_load_i |=> // see RL19
    cr0_reg[31:16] == $past(cr0_reg[31:16]) && (pe || !$past(pe)))
    else $error("status word load touched upper bits");

endmodule

`default_nettype wire

// ===== dv/tb_cfss_state.sv
/*
  Self-checking bench for the flags, segment and control state.
  Assumes cfss_state alone, driven directly by the bench.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_cfss_state;
  logic        sys_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        ce_i = 1'b1;
  logic        alu_valid_i = 1'b0, alu_sub_i = 1'b0, flags_wr_i = 1'b0;
  logic        str_step_i = 1'b0, instr_done_i = 1'b0;
  logic        maskable_interrupt_input_i = 1'b0;
  logic        seg_load_i = 1'b0, mem_req_i = 1'b0;
  logic        cr_wr_i = 1'b0, cr_rd_i = 1'b0;
  logic        msw_load_i = 1'b0, msw_store_i = 1'b0;
  logic [1:0]  alu_size_i = '0, cpl_i = '0, str_size_i = '0;
  logic [1:0]  mem_len_i = '0, mem_acc_i = '0, cr_num_i = '0;
  logic [2:0]  seg_idx_i = '0, seg_rd_idx_i = '0, mem_seg_i = '0;
  logic [3:0]  bp_match_i = '0;
  logic [7:0]  desc_attr_i = '0;
  logic [15:0] seg_sel_i = '0;
  logic [31:0] alu_a_i = '0, alu_b_i = '0, flags_wdata_i = '0;
  logic [31:0] str_src_i = '0, str_dst_i = '0, desc_base_i = '0;
  logic [31:0] desc_limit_i = '0, mem_off_i = '0, cr_wdata_i = '0;
  logic [31:0] flags_o, str_src_o, str_dst_o, mem_lin_o, cr_rdata_o;
  logic [15:0] seg_sel_o;
  logic [7:0]  fault_vec_o;
  logic        int_req_o, debug_trap_o, mem_valid_o, mem_fault_o;
  logic        paging_enable_o, protect_mode_o;
  int          errors = 0;
  int          n_checks = 0;

  cfss_state i_cfss_state (
    .sys_clk_i, .sys_rst_i, .ce_i, .alu_valid_i, .alu_sub_i, .alu_size_i,
    .alu_a_i, .alu_b_i, .flags_wr_i, .flags_wdata_i, .cpl_i, .flags_o,
    .str_step_i, .str_size_i, .str_src_i, .str_dst_i, .str_src_o,
    .str_dst_o, .maskable_interrupt_input_i, .int_req_o, .instr_done_i,
    .bp_match_i, .debug_trap_o, .fault_vec_o, .seg_load_i, .seg_idx_i,
    .seg_sel_i, .desc_base_i, .desc_limit_i, .desc_attr_i, .seg_rd_idx_i,
    .seg_sel_o, .mem_req_i, .mem_seg_i, .mem_off_i, .mem_len_i, .mem_acc_i,
    .mem_valid_o, .mem_lin_o, .mem_fault_o, .cr_wr_i, .cr_rd_i, .cr_num_i,
    .cr_wdata_i, .msw_load_i, .msw_store_i, .cr_rdata_o, .paging_enable_o,
    .protect_mode_o
  );

  initial
  begin
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  task automatic end_of_test();
    if (errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cyc(input int n = 1);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic alu(input logic sub, input logic [1:0] sz,
                     input logic [31:0] a, input logic [31:0] b);
    alu_valid_i = 1'b1;
    alu_sub_i = sub;
    alu_size_i = sz;
    alu_a_i = a;
    alu_b_i = b;
    cyc();
    alu_valid_i = 1'b0;
  endtask

  task automatic pop(input logic [31:0] img, input logic [1:0] current_privilege_level);
    flags_wr_i = 1'b1;
    flags_wdata_i = img;
    cpl_i = current_privilege_level;
    cyc();
    flags_wr_i = 1'b0;
  endtask

  task automatic str(input logic [1:0] sz);
    str_step_i = 1'b1;
    str_size_i = sz;
    str_src_i = 32'h0000_0100;
    str_dst_i = 32'h0000_0200;
    cyc();
    str_step_i = 1'b0;
  endtask

  task automatic dbg(input logic [3:0] bp, input logic exp);
    instr_done_i = 1'b1;
    bp_match_i = bp;
    cyc();
    instr_done_i = 1'b0;
    bp_match_i = '0;
    chk(debug_trap_o, exp);
  endtask

  task automatic seg(input logic [2:0] idx, input logic [15:0] sel,
                     input logic [31:0] base, input logic [31:0] lim,
                     input logic [7:0] attr);
    seg_load_i = 1'b1;
    seg_idx_i = idx;
    seg_sel_i = sel;
    desc_base_i = base;
    desc_limit_i = lim;
    desc_attr_i = attr;
    cyc();
    seg_load_i = 1'b0;
  endtask

  task automatic mem(input logic [2:0] sg, input logic [31:0] off,
                     input logic [1:0] len, input logic [1:0] acc,
                     input logic [31:0] lin, input logic flt);
    mem_req_i = 1'b1;
    mem_seg_i = sg;
    mem_off_i = off;
    mem_len_i = len;
    mem_acc_i = acc;
    cyc();
    mem_req_i = 1'b0;
    chk(mem_valid_o, 1'b1);
    chk(mem_fault_o, flt);
    if (!flt)
      chk(mem_lin_o, lin);
  endtask

  task automatic cr(input logic wr, input logic [1:0] num,
                    input logic [31:0] d);
    cr_wr_i = wr;
    cr_rd_i = ~wr;
    cr_num_i = num;
    cr_wdata_i = d;
    cyc();
    cr_wr_i = 1'b0;
    cr_rd_i = 1'b0;
  endtask

  initial
  begin
    #(40 * 2000);
    errors++;
    end_of_test();
  end

  initial
  begin
    cyc(10);
    sys_rst_i = 1'b0;
    chk(flags_o, 32'h0000_0000);
    chk(paging_enable_o, 1'b0);
    // Arithmetic flags at each operand size
    alu(1'b0, cfss_pkg::SZ8, 32'h0000_007F, 32'h0000_0001);
    chk(flags_o, 32'h0000_0890);
    alu(1'b0, cfss_pkg::SZ8, 32'h0000_00FF, 32'h0000_0001);
    chk(flags_o, 32'h0000_0055);
    alu(1'b1, cfss_pkg::SZ16, 32'h0000_0000, 32'h0000_0001);
    chk(flags_o, 32'h0000_0095);
    alu(1'b0, cfss_pkg::SZ32, 32'h7FFF_FFFF, 32'h0000_0001);
    chk(flags_o, 32'h0000_0894);
    ce_i = 1'b0;
    alu(1'b0, cfss_pkg::SZ8, 32'h0000_00FF, 32'h0000_0001);
    ce_i = 1'b1;
    chk(flags_o, 32'h0000_0894);
    // Control flags, privilege gating, strings, traps
    pop(32'h0000_3700, 2'h0);
    chk(flags_o, 32'h0000_3700);
    str(cfss_pkg::SZ16);
    chk(str_src_o, 32'h0000_00FE);
    chk(str_dst_o, 32'h0000_01FE);
    dbg(4'h0, 1'b1);
    chk(fault_vec_o, 32'h0000_0001);
    maskable_interrupt_input_i = 1'b1;
    cyc(2);
    chk(int_req_o, 1'b1);
    pop(32'h0000_0000, 2'h3);
    chk(flags_o, 32'h0000_3000);
    chk(int_req_o, 1'b0);
    pop(32'h0000_1200, 2'h0);
    chk(int_req_o, 1'b1);
    pop(32'h0000_0000, 2'h3);
    chk(flags_o, 32'h0000_1200);
    maskable_interrupt_input_i = 1'b0;
    str(cfss_pkg::SZ32);
    chk(str_src_o, 32'h0000_0104);
    chk(str_dst_o, 32'h0000_0204);
    dbg(4'h0, 1'b0);
    dbg(4'h4, 1'b1);
    str(cfss_pkg::SZ8);
    chk(str_dst_o, 32'h0000_0201);
    // Real mode segments
    seg(3'h2, 16'h1234, 32'h0000_0000, 32'h0000_0000, 8'h00);
    seg_rd_idx_i = 3'h2;
    cyc();
    chk(seg_sel_o, 32'h0000_1234);
    mem(3'h2, 32'h0000_0010, 2'h0, 2'h0, 32'h0001_2350, 1'b0);
    mem(3'h2, 32'h0000_FFFF, 2'h0, 2'h1, 32'h0002_233F, 1'b0);
    mem(3'h2, 32'h0000_FFFF, 2'h1, 2'h0, 32'h0000_0000, 1'b1);
    chk(fault_vec_o, 32'h0000_000D);
    // Same-cycle selector load and reference on one segment
    seg_load_i = 1'b1;
    seg_idx_i = 3'h1;
    seg_sel_i = 16'h0100;
    mem(3'h1, 32'h0000_0004, 2'h0, 2'h0, 32'h0000_1004, 1'b0);
    seg_load_i = 1'b0;
    // Control registers and status word alias
    cr(1'b1, 2'h0, 32'h8000_0011);
    chk(paging_enable_o, 1'b1);
    cr(1'b0, 2'h0, 32'h0000_0000);
    chk(cr_rdata_o, 32'h8000_0001);
    cr(1'b1, 2'h3, 32'hFFFF_FFFF);
    cr(1'b0, 2'h3, 32'h0000_0000);
    chk(cr_rdata_o, 32'hFFFF_F000);
    cr(1'b1, 2'h2, 32'h1357_9BDF);
    cr(1'b0, 2'h2, 32'h0000_0000);
    chk(cr_rdata_o, 32'h1357_9BDF);
    msw_load_i = 1'b1;
    cr_wdata_i = 32'h0000_0012;
    cyc();
    msw_load_i = 1'b0;
    msw_store_i = 1'b1;
    cyc();
    msw_store_i = 1'b0;
    chk(cr_rdata_o, 32'h0000_0003);
    cr(1'b0, 2'h0, 32'h0000_0000);
    chk(cr_rdata_o, 32'h8000_0003);
    // Protected mode descriptor caches
    seg(3'h3, 16'h0018, 32'h1000_0000, 32'hFFFF_FFFF, 8'h93);
    mem(3'h3, 32'h0000_0010, 2'h3, 2'h1, 32'h1000_0010, 1'b0);
    mem(3'h3, 32'hFFFF_FFFE, 2'h3, 2'h0, 32'h0000_0000, 1'b1);
    mem(3'h3, 32'h0000_0010, 2'h0, 2'h2, 32'h0000_0000, 1'b1);
    seg(3'h4, 16'h0020, 32'h0000_0000, 32'h0000_FFFF, 8'h13);
    mem(3'h4, 32'h0000_0000, 2'h0, 2'h0, 32'h0000_0000, 1'b1);
    seg(3'h0, 16'h0008, 32'h0040_0000, 32'h0000_00FF, 8'h9A);
    mem(3'h0, 32'h0000_00FF, 2'h0, 2'h2, 32'h0040_00FF, 1'b0);
    mem(3'h0, 32'h0000_0100, 2'h0, 2'h2, 32'h0000_0000, 1'b1);
    mem(3'h0, 32'h0000_0000, 2'h0, 2'h1, 32'h0000_0000, 1'b1);
    cr(1'b1, 2'h0, 32'h0000_0000);
    chk(paging_enable_o, 1'b0);
    chk(protect_mode_o, 1'b0);
    end_of_test();
  end
endmodule

`default_nettype wire
